// file: core/adc_aux_gain_offset_cal.sv
// Auxiliary-channel ADC gain and offset calibration registers and result path
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
// Operation
// - Unity-PGA gain register corrects all channels but TIA and temperature at PGA gain 1.
// - PGA 1.5 gain register corrects all channels but TIA and temperature at gain 1.5.
// - Gain field is 15 bits, unsigned, bit 14 integer, bits 13..0 fraction.
// - Gain code 0x4000 multiplies by exactly one; it is the default.
// - Gain code 0x2000 scales the result by one half.
// - Code 0x7FFF scales by about two; 0x4001 is the smallest step above one.
// - Code 0x0001 is the smallest multiplier; 0x3FFF is just below one.
// - Zero unity-PGA gain code forces the corrected result to 0x8000.
// - Zero PGA 1.5 gain code forces the corrected result to zero.
// - PGA 1.5 offset register corrects only conversions taken at PGA gain 1.5.
// - Offset 0x3FFF adds 4095.75 LSB; 0x0001 adds 0.25 LSB.
// - Offset 0x4000 subtracts 4096 LSB; 0x7FFF subtracts 0.25 LSB.
// - Offset code zero applies no offset correction.
// - Gain registers reset to 0x4000, the offset register to zero.
// - Offsets are twos complement in quarter-LSB steps of the result.
module adc_aux_gain_offset_cal
  import adc_cal_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DATA_W-1:0] O_RDATA,
  input  wire logic              I_SAMPLE_VALID,
  input  wire logic [RES_W-1:0]  I_SAMPLE_DATA,
  input  wire logic [1:0]        I_PGA_SEL,
  input  wire logic              I_CHAN_EXCLUDED,
  output logic                   O_RESULT_VALID,
  output logic      [RES_W-1:0]  O_RESULT
);

  logic [CAL_W-1:0]  gain_unity_reg;
  logic [CAL_W-1:0]  gain_half_reg;
  logic [CAL_W-1:0]  offs_half_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  logic                    s1_valid_reg;
  logic                    s1_pass_reg;
  logic                    s1_zero_reg;
  logic [RES_W-1:0]        s1_raw_reg;
  logic signed [SUM_W-1:0] s1_sum_reg;
  logic [CAL_W-1:0]        s1_gain_reg;
  logic                    res_valid_reg;
  logic [RES_W-1:0]        result_reg;
  logic [RES_W-1:0]        result_next;

  // Register decode
  wire hit_gain_unity = (I_ADDR == GAIN_UNITY_ADDR);
  wire hit_gain_half  = (I_ADDR == GAIN_HALF_ADDR);
  wire hit_offs_half  = (I_ADDR == OFFS_HALF_ADDR);
  wire hit_result     = (I_ADDR == RESULT_ADDR);

  // Reserved bits read as zero, unmapped reads return zero
  assign rdata_next = !I_RD          ? rdata_reg :
                      hit_gain_unity ? {{RSVD_W{1'b0}}, gain_unity_reg} :
                      hit_gain_half  ? {{RSVD_W{1'b0}}, gain_half_reg} :
                      hit_offs_half  ? {{RSVD_W{1'b0}}, offs_half_reg} :
                      hit_result     ? {{RES_RSVD_W{1'b0}}, result_reg} :
                      RDATA_ZERO;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      gain_unity_reg <= GAIN_RESET;
      gain_half_reg  <= GAIN_RESET;
      offs_half_reg  <= OFFSET_RESET;
    end else if (I_WR) begin
      if (hit_gain_unity) begin
        gain_unity_reg <= I_WDATA[CAL_W-1:0];
      end
      if (hit_gain_half) begin
        gain_half_reg <= I_WDATA[CAL_W-1:0];
      end
      if (hit_offs_half) begin
        offs_half_reg <= I_WDATA[CAL_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_reg <= RDATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Stage 1: pick the calibration set for this conversion and add the offset
  wire use_unity = (I_PGA_SEL == PGA_SEL_1) && !I_CHAN_EXCLUDED;
  wire use_half  = (I_PGA_SEL == PGA_SEL_1P5) && !I_CHAN_EXCLUDED;
  wire pass_thru = !use_unity && !use_half;

  wire [CAL_W-1:0] sel_gain = use_half ? gain_half_reg : gain_unity_reg;
  // Offset reaches only PGA 1.5 conversions
  wire [CAL_W-1:0] sel_offs = use_half ? offs_half_reg : OFFSET_RESET;
  wire sel_zero = use_half && (gain_half_reg == GAIN_ILLEGAL);

  // Centre on mid-scale so a zero gain lands on 0x8000 for the unity path
  wire signed [RES_W:0] centered =
    $signed({1'b0, I_SAMPLE_DATA}) - $signed({1'b0, MID_SCALE});
  wire signed [SUM_W-1:0] centered_q = {centered[RES_W], centered, {OFFS_FRAC{1'b0}}};
  wire signed [SUM_W-1:0] offs_ext =
    {{(SUM_W-CAL_W){sel_offs[CAL_W-1]}}, sel_offs};
  wire signed [SUM_W-1:0] sum_q = centered_q + offs_ext;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s1_valid_reg <= 1'b0;
      s1_pass_reg  <= 1'b0;
      s1_zero_reg  <= 1'b0;
      s1_raw_reg   <= ZERO_RESULT;
      s1_sum_reg   <= '0;
      s1_gain_reg  <= GAIN_RESET;
    end else if (I_SAMPLE_VALID) begin
      s1_valid_reg <= 1'b1;
      s1_pass_reg  <= pass_thru;
      s1_zero_reg  <= sel_zero;
      s1_raw_reg   <= I_SAMPLE_DATA;
      s1_sum_reg   <= sum_q;
      s1_gain_reg  <= sel_gain;
    end else begin
      s1_valid_reg <= 1'b0;
    end
  end

  // Stage 2: unsigned gain with 14 fraction bits, so 0x7FFF is just under two
  wire signed [PROD_W-1:0] prod =
    PROD_W'(s1_sum_reg) * PROD_W'($signed({1'b0, s1_gain_reg}));
  // Floor by dropping bits keeps 0x4000 with zero offset an exact identity
  wire signed [SUM_W-1:0] scaled = prod[SHIFT +: SUM_W];
  wire signed [SUM_W:0] uncentered =
    {scaled[SUM_W-1], scaled} + $signed({{(SUM_W-RES_W+1){1'b0}}, MID_SCALE});
  wire too_low  = uncentered[SUM_W];
  wire too_high = !too_low && (uncentered[SUM_W-1:RES_W] != '0);

  // Saturate rather than wrap, a wrapped code would flip full scale
  assign result_next = s1_pass_reg ? s1_raw_reg :
                       s1_zero_reg ? ZERO_RESULT :
                       too_low     ? ZERO_RESULT :
                       too_high    ? FULL_SCALE :
                       uncentered[RES_W-1:0];

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      res_valid_reg <= 1'b0;
      result_reg    <= ZERO_RESULT;
    end else begin
      res_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        result_reg <= result_next;
      end
    end
  end

  assign O_RDATA        = rdata_reg;
  assign O_RESULT_VALID = res_valid_reg;
  assign O_RESULT       = result_reg;

  // Checks
  sequence unity_sample_s(logic [14:0] g);
    I_SAMPLE_VALID && use_unity && (gain_unity_reg == g);
  endsequence

  sequence half_sample_s(logic [14:0] g, logic [14:0] o);
    I_SAMPLE_VALID && use_half && (gain_half_reg == g) && (offs_half_reg == o);
  endsequence

  sequence result_out_s;
    ##2 O_RESULT_VALID;
  endsequence

  reset_values_a: assert property (@(posedge I_CLK)
    $fell(I_SYS_RST) |-> gain_unity_reg == GAIN_RESET && gain_half_reg == GAIN_RESET
      && offs_half_reg == OFFSET_RESET)
    else $error("calibration register reset value wrong");

  read_field_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && hit_gain_half |=> O_RDATA == {{RSVD_W{1'b0}}, $past(gain_half_reg)})
    else $error("gain register readback wrong");

  unity_ident_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(GAIN_RESET) |-> ##2 O_RESULT == $past(I_SAMPLE_DATA, 2))
    else $error("unity gain changed the result");

  unity_zero_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(GAIN_ILLEGAL) |-> ##2 O_RESULT == MID_SCALE)
    else $error("zero unity gain did not give mid-scale");

  half_zero_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_SAMPLE_VALID && use_half && gain_half_reg == GAIN_ILLEGAL |-> ##2 O_RESULT == ZERO_RESULT)
    else $error("zero gain at PGA 1.5 did not give zero");

  half_ident_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, OFFSET_RESET) |-> ##2 O_RESULT == $past(I_SAMPLE_DATA, 2))
    else $error("zero offset changed the result");

  half_scale_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h2000) ##0 I_SAMPLE_DATA == 16'hC000 |-> ##2 O_RESULT == 16'hA000)
    else $error("half gain wrong");

  offs_step_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, 15'h0004) ##0 I_SAMPLE_DATA != FULL_SCALE
      |-> ##2 O_RESULT == $past(I_SAMPLE_DATA, 2) + 16'h0001)
    else $error("four quarter steps did not add one LSB");

  offs_neg_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, 15'h7FFC) ##0 I_SAMPLE_DATA != ZERO_RESULT
      |-> ##2 O_RESULT == $past(I_SAMPLE_DATA, 2) - 16'h0001)
    else $error("negative offset wrong");

  excluded_pass_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_SAMPLE_VALID && pass_thru |-> ##2 O_RESULT == $past(I_SAMPLE_DATA, 2))
    else $error("uncorrected channel was altered");

  result_time_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_SAMPLE_VALID |-> result_out_s)
    else $error("result not ready two cycles after sample");

  no_spurious_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_RESULT_VALID |-> $past(I_SAMPLE_VALID, 2) || $past(I_SYS_RST, 2))
    else $error("result valid without a sample");

  read_unity_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && hit_gain_unity |=> O_RDATA == {{RSVD_W{1'b0}}, $past(gain_unity_reg)})
    else $error("unity gain readback wrong");

  read_offs_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && hit_offs_half |=> O_RDATA == {{RSVD_W{1'b0}}, $past(offs_half_reg)})
    else $error("offset readback wrong");

  read_result_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && hit_result |=> O_RDATA == {{RES_RSVD_W{1'b0}}, $past(result_reg)})
    else $error("result readback wrong");

  read_unmapped_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && !hit_gain_unity && !hit_gain_half && !hit_offs_half && !hit_result
      |=> O_RDATA == RDATA_ZERO)
    else $error("unmapped read not zero");

  write_unity_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && hit_gain_unity |=> gain_unity_reg == $past(I_WDATA[CAL_W-1:0]))
    else $error("unity gain write lost");

  write_half_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && hit_gain_half |=> gain_half_reg == $past(I_WDATA[CAL_W-1:0]))
    else $error("PGA 1.5 gain write lost");

  write_offs_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && hit_offs_half |=> offs_half_reg == $past(I_WDATA[CAL_W-1:0]))
    else $error("offset write lost");

  cal_hold_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !I_WR |=> $stable(gain_unity_reg) && $stable(gain_half_reg) && $stable(offs_half_reg))
    else $error("calibration register changed without a write");

  max_gain_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h7FFF) ##0 I_SAMPLE_DATA == 16'hC000 |-> ##2 O_RESULT == FULL_SCALE)
    else $error("top gain code wrong");

  min_step_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h4001) ##0 I_SAMPLE_DATA == 16'hC000 |-> ##2 O_RESULT == 16'hC001)
    else $error("smallest step above unity wrong");

  min_gain_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h0001) ##0 I_SAMPLE_DATA == 16'hC000 |-> ##2 O_RESULT == 16'h8001)
    else $error("smallest gain code wrong");

  below_unity_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h3FFF) ##0 I_SAMPLE_DATA == 16'hC000 |-> ##2 O_RESULT == 16'hBFFF)
    else $error("gain just below unity wrong");

  clamp_high_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h7FFF) ##0 I_SAMPLE_DATA == FULL_SCALE |-> ##2 O_RESULT == FULL_SCALE)
    else $error("high result did not saturate");

  clamp_low_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    unity_sample_s(15'h7FFF) ##0 I_SAMPLE_DATA == ZERO_RESULT |-> ##2 O_RESULT == ZERO_RESULT)
    else $error("low result did not saturate");

  half_gain_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(15'h2000, OFFSET_RESET) ##0 I_SAMPLE_DATA == 16'hC000
      |-> ##2 O_RESULT == 16'hA000)
    else $error("PGA 1.5 half gain wrong");

  half_max_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(15'h7FFF, OFFSET_RESET) ##0 I_SAMPLE_DATA == 16'hC000
      |-> ##2 O_RESULT == FULL_SCALE)
    else $error("PGA 1.5 top gain wrong");

  offs_max_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, 15'h3FFF) ##0 I_SAMPLE_DATA == MID_SCALE |-> ##2 O_RESULT == 16'h8FFF)
    else $error("largest positive offset wrong");

  offs_most_neg_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, 15'h4000) ##0 I_SAMPLE_DATA == MID_SCALE |-> ##2 O_RESULT == 16'h7000)
    else $error("most negative offset wrong");

  offs_quarter_neg_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    half_sample_s(GAIN_RESET, 15'h7FFF) ##0 I_SAMPLE_DATA == MID_SCALE |-> ##2 O_RESULT == 16'h7FFF)
    else $error("quarter negative offset wrong");

  valid_pulse_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_SAMPLE_VALID ##1 !I_SAMPLE_VALID |-> ##2 !O_RESULT_VALID)
    else $error("result valid longer than one cycle");

  result_hold_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !I_SAMPLE_VALID |-> ##2 $stable(O_RESULT))
    else $error("result changed without a sample");

endmodule : adc_aux_gain_offset_cal

// file: core/adc_cal_pkg.sv
// Constants shared by the auxiliary-channel gain and offset calibration block
package adc_cal_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CAL_W  = 15;
  localparam int RES_W  = 16;

  // Register byte addresses
  localparam logic [15:0] GAIN_UNITY_ADDR = 16'h2240;
  localparam logic [15:0] GAIN_HALF_ADDR  = 16'h2270;
  localparam logic [15:0] OFFS_HALF_ADDR  = 16'h22CC;
  localparam logic [15:0] RESULT_ADDR     = 16'h2300;

  // Field values
  localparam logic [14:0] GAIN_RESET    = 15'h4000;
  localparam logic [14:0] OFFSET_RESET  = 15'h0000;
  localparam logic [14:0] GAIN_ILLEGAL  = 15'h0000;
  localparam logic [15:0] MID_SCALE     = 16'h8000;
  localparam logic [15:0] ZERO_RESULT   = 16'h0000;
  localparam logic [15:0] FULL_SCALE    = 16'hFFFF;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  localparam int          RSVD_W        = DATA_W - CAL_W;
  localparam int          RES_RSVD_W    = DATA_W - RES_W;

  // Fixed-point layout: gain has 14 fraction bits, offset 2 (quarter LSB)
  localparam int GAIN_FRAC = 14;
  localparam int OFFS_FRAC = 2;
  localparam int SUM_W     = RES_W + 1 + OFFS_FRAC + 1;
  localparam int PROD_W    = SUM_W + CAL_W + 1;
  localparam int SHIFT     = GAIN_FRAC + OFFS_FRAC;

  // PGA setting codes on the conversion input
  localparam logic [1:0] PGA_SEL_1   = 2'h0;
  localparam logic [1:0] PGA_SEL_1P5 = 2'h1;
endpackage : adc_cal_pkg

// file: verif/adc_aux_gain_offset_cal_test.sv
// Self-checking bench for the auxiliary-channel calibration registers and result path
`timescale 1ns/10ps
module adc_aux_gain_offset_cal_test;
  import adc_cal_pkg::*;
  logic              clk     = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] addr    = '0;
  logic [DATA_W-1:0] wdata   = '0;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              s_valid = 1'b0;
  logic [RES_W-1:0]  s_data  = '0;
  logic [1:0]        pga     = '0;
  logic              excl    = 1'b0;
  logic              r_valid;
  logic [RES_W-1:0]  result;
  logic [CAL_W-1:0]  g1      = GAIN_RESET;
  logic [CAL_W-1:0]  g15     = GAIN_RESET;
  logic [CAL_W-1:0]  o15     = OFFSET_RESET;
  int                n_fail  = 0;
  int                comparisons = 0;
  logic [14:0] codes [7] = '{15'h4000, 15'h2000, 15'h7FFF, 15'h4001, 15'h0001, 15'h3FFF, 15'h0000};
  logic [14:0] offs  [7] = '{15'h3FFF, 15'h0001, 15'h0000, 15'h7FFF, 15'h4000, 15'h0004, 15'h7FFC};
  logic [15:0] dats  [3] = '{16'hC000, 16'h0000, 16'hFFFF};

  always #2.5 clk = ~clk;

  adc_aux_gain_offset_cal u_adc_aux_gain_offset_cal (
    .I_CLK(clk), .I_SYS_RST(sys_rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_SAMPLE_VALID(s_valid), .I_SAMPLE_DATA(s_data), .I_PGA_SEL(pga),
    .I_CHAN_EXCLUDED(excl), .O_RESULT_VALID(r_valid), .O_RESULT(result));

  task automatic test_done;
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rd_reg

  // Reference arithmetic: quarter-LSB sum, 1.14 gain, floor, then clamp to the code range
  function automatic logic [15:0] model(input logic [15:0] d, input logic [1:0] p,
                                        input logic x);
    longint s;
    longint g;
    if (x || p > 2'h1) return d;
    g = (p == PGA_SEL_1P5) ? longint'(g15) : longint'(g1);
    if (p == PGA_SEL_1P5 && g == 0) return ZERO_RESULT;
    s = (longint'(d) - 32768) * 4;
    if (p == PGA_SEL_1P5) s = s + longint'($signed(o15));
    s = ((s * g) >>> 16) + 32768;
    if (s < 0) s = 0;
    if (s > 65535) s = 65535;
    return s[15:0];
  endfunction : model

  // The result is judged only in the one cycle in which its valid pulse stands
  task automatic conv(input logic [15:0] d, input logic [1:0] p, input logic x);
    logic [15:0] e;
    e = model(d, p, x);
    @(posedge clk);
    s_data  <= d;
    pga     <= p;
    excl    <= x;
    s_valid <= 1'b1;
    @(posedge clk);
    s_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk("result_valid", {31'h0, r_valid}, 32'h1);
    chk("result", {16'h0, result}, {16'h0, e});
    @(posedge clk);
    #1;
    chk("result_valid_low", {31'h0, r_valid}, 32'h0);
  endtask : conv

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(GAIN_UNITY_ADDR, 32'h0000_4000);
    rd_reg(GAIN_HALF_ADDR, 32'h0000_4000);
    rd_reg(OFFS_HALF_ADDR, RDATA_ZERO);
    conv(16'hC000, PGA_SEL_1, 1'b0);
    wr_reg(16'h2244, 32'hFFFF_FFFF);
    rd_reg(16'h2244, RDATA_ZERO);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 7; i++) begin
        wr_reg(r ? GAIN_HALF_ADDR : GAIN_UNITY_ADDR, {17'h1FFFF, codes[i]});
        if (r) g15 = codes[i];
        else g1 = codes[i];
        rd_reg(r ? GAIN_HALF_ADDR : GAIN_UNITY_ADDR, {17'h0, codes[i]});
        for (int k = 0; k < 3; k++) begin
          conv(dats[k], r[1:0], 1'b0);
          conv(dats[k], r[1:0], 1'b1);
        end
      end
    end
    wr_reg(GAIN_HALF_ADDR, 32'h0000_4000);
    g15 = GAIN_RESET;
    // Unity gain back to one, so an offset leaking into gain-1 conversions shows up
    wr_reg(GAIN_UNITY_ADDR, 32'h0000_4000);
    g1 = GAIN_RESET;
    for (int i = 0; i < 7; i++) begin
      wr_reg(OFFS_HALF_ADDR, {17'h1FFFF, offs[i]});
      o15 = offs[i];
      rd_reg(OFFS_HALF_ADDR, {17'h0, offs[i]});
      conv(16'h8000, PGA_SEL_1P5, 1'b0);
      conv(16'h0001, PGA_SEL_1P5, 1'b0);
      conv(16'h8000, PGA_SEL_1, 1'b0);
      conv(16'h8000, 2'h2, 1'b0);
      conv(16'h1234, 2'h3, 1'b0);
    end
    rd_reg(GAIN_UNITY_ADDR, {17'h0, g1});
    wr_reg(RESULT_ADDR, 32'hFFFF_FFFF);
    rd_reg(RESULT_ADDR, 32'h0000_1234);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(GAIN_UNITY_ADDR, {17'h0, GAIN_RESET});
    rd_reg(GAIN_HALF_ADDR, {17'h0, GAIN_RESET});
    rd_reg(OFFS_HALF_ADDR, RDATA_ZERO);
    rd_reg(RESULT_ADDR, RDATA_ZERO);
    test_done();
  end

  // Roughly 180 register and sample operations of a few cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : adc_aux_gain_offset_cal_test
